/* File: inc/csr_consts.svh */
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH
// Seven-bit slave address of the device
`define CSR_DEV_ADDR 7'h48
// Register subaddresses
`define CSR_A_STATUS 8'h00
`define CSR_A_VTERM 8'h02
`define CSR_A_ICUR 8'h04
`define CSR_A_UNLOCK 8'h11
`define CSR_A_NVCTRL 8'h12
// Status bit positions
`define CSR_B_OV 7
`define CSR_B_TSD 3
`define CSR_B_UV 1
`define CSR_FAULT_MASK 8'h88
`define CSR_WARN_ONLY 8'h02
// Field positions in the configuration registers
`define CSR_VTERM_LSB 3
`define CSR_VTERM_MSB 5
`define CSR_ICUR_LSB 4
`define CSR_ICUR_MSB 7
// Control bit position in unlock and program registers
`define CSR_B_CTRL 0
// Reset values
`define CSR_STATUS_RST 8'h00
`define CSR_ZERO8 8'h00
// Bits per byte on the serial link
`define CSR_BYTE_BITS 4'h8
`define CSR_CNT_ONE 4'h1
`define CSR_SUB_STEP 8'h01
`endif

/* File: inc/csr_pkg.sv */
package csr_pkg;
   // Serial engine states
   typedef enum logic [3:0] {
      csr_st_idle, csr_st_addr, csr_st_ack_addr, csr_st_sub, csr_st_ack_sub,
      csr_st_wr, csr_st_ack_wr, csr_st_rd, csr_st_ack_rd
   } csr_state_e;
   // Values exchanged with the nonvolatile store
   typedef struct packed {
      logic [2:0] vterm;
      logic [3:0] charge_current_code;
   } csr_nv_cfg_s;
   // Detector levels from the protection circuits
   typedef struct packed {
      logic output_overvoltage_flag;
      logic thermal_shutdown_flag;
      logic input_undervoltage_flag;
   } csr_events_s;
endpackage : csr_pkg

/* File: core/csr_regs.sv */
`timescale 1ns/100ps
`include "csr_consts.svh"
// Function
// - Answer as serial slave at seven-bit address 48 hex.
// - Acknowledge a matching address byte by pulling data low.
// - Status register resets to zero and ignores writes.
// - Over-voltage and thermal flags are faults and pull fault pin low.
// - Under-voltage flag is a warning and never pulls the fault pin.
// - Reading the status register clears all status bits whose event is no longer present.
// - Fault pin releases only after a read cleared every fault bit.
// - Configuration and program registers locked until unlock bit is one.
// - Unlock register resets to zero; only bit zero is writable.
// - Unlock bit gates reads and writes of 02 and 04.
// - Register 02 holds the three-bit termination voltage code.
// - Register 04 holds the four-bit maximum charge current code.
// - Program register resets to zero; only bit zero is writable.
// - Writing one to program bit starts storing registers 2 and 4.
module csr_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic fault_out_n,
   output logic fault_oe_n,
   input wire csr_pkg::csr_events_s event_in,
   input wire csr_pkg::csr_nv_cfg_s nv_cfg_in,
   output csr_pkg::csr_nv_cfg_s nv_cfg_out,
   output logic nonvolatile_program_bit,
   output logic nv_prog_start
);
   import csr_pkg::*;

   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   csr_events_s evt_m, evt_s;
   logic scl_rise, scl_fall, start_det, stop_det;
   csr_state_e state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] sub_addr;
   logic rw_bit, master_nack;
   logic [7:0] status, next_status, evt_bits, rd_data;
   logic cfg_unlocked, load_pending;
   logic wr_now, rd_load_now, status_clr, cfg_addr, any_evt;

   // ----------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------
   // Pins and analog detectors are asynchronous to clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         evt_m <= '0;
         evt_s <= '0;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         evt_m <= event_in;
         evt_s <= evt_m;
      end
   end

   // Bus conditions seen on the synchronised lines
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------
   // A byte is written at the falling edge that ends its eighth bit
   assign wr_now = scl_fall && (state == csr_st_wr) && (bit_cnt == `CSR_BYTE_BITS);
   // A read byte is fetched when the preceding acknowledge ends
   assign rd_load_now = scl_fall && (((state == csr_st_ack_addr) && rw_bit) ||
                                     ((state == csr_st_ack_rd) && !master_nack));
   assign status_clr = rd_load_now && (sub_addr == `CSR_A_STATUS);
   assign cfg_addr = (sub_addr == `CSR_A_VTERM) || (sub_addr == `CSR_A_ICUR) ||
                     (sub_addr == `CSR_A_NVCTRL);
   assign any_evt = |evt_bits;

   // Read multiplexer; locked and unmapped addresses give zero
   always_comb begin
      rd_data = `CSR_ZERO8;
      case (sub_addr)
         `CSR_A_STATUS: rd_data = status;
         `CSR_A_VTERM: if (cfg_unlocked)
            rd_data[`CSR_VTERM_MSB:`CSR_VTERM_LSB] = nv_cfg_out.vterm;
         `CSR_A_ICUR: if (cfg_unlocked)
            rd_data[`CSR_ICUR_MSB:`CSR_ICUR_LSB] = nv_cfg_out.charge_current_code;
         `CSR_A_UNLOCK: rd_data[`CSR_B_CTRL] = cfg_unlocked;
         `CSR_A_NVCTRL: if (cfg_unlocked)
            rd_data[`CSR_B_CTRL] = nonvolatile_program_bit;
         default: rd_data = `CSR_ZERO8;
      endcase
   end

   // ----------------------------------------------------------
   // Serial slave engine
   // ----------------------------------------------------------
   // Subaddress auto-increments so bursts walk the map
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= csr_st_idle;
         bit_cnt <= '0;
         shift <= '0;
         sub_addr <= '0;
         rw_bit <= 1'b0;
         master_nack <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (start_det) begin
         // Repeated start keeps the subaddress for a following read
         state <= csr_st_addr;
         bit_cnt <= '0;
         sda_oe_n <= 1'b1;
      end else if (stop_det) begin
         state <= csr_st_idle;
         sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
         unique case (state)
            csr_st_addr, csr_st_sub, csr_st_wr: begin
               shift <= {shift[6:0], sda_s};
               bit_cnt <= bit_cnt + `CSR_CNT_ONE;
            end
            csr_st_ack_rd: master_nack <= sda_s;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (state)
            csr_st_idle: ;
            csr_st_addr: if (bit_cnt == `CSR_BYTE_BITS) begin
               bit_cnt <= '0;
               if (shift[7:1] == `CSR_DEV_ADDR) begin
                  state <= csr_st_ack_addr;
                  rw_bit <= shift[0];
                  sda_oe_n <= 1'b0;
               end else begin
                  state <= csr_st_idle;
               end
            end
            csr_st_ack_addr: if (rw_bit) begin
               state <= csr_st_rd;
               shift <= rd_data;
               sda_oe_n <= rd_data[7];
               bit_cnt <= `CSR_CNT_ONE;
            end else begin
               state <= csr_st_sub;
               sda_oe_n <= 1'b1;
            end
            csr_st_sub: if (bit_cnt == `CSR_BYTE_BITS) begin
               sub_addr <= shift;
               state <= csr_st_ack_sub;
               sda_oe_n <= 1'b0;
               bit_cnt <= '0;
            end
            csr_st_ack_sub, csr_st_ack_wr: begin
               state <= csr_st_wr;
               sda_oe_n <= 1'b1;
            end
            csr_st_wr: if (bit_cnt == `CSR_BYTE_BITS) begin
               // Every data byte is acknowledged, even when ignored
               state <= csr_st_ack_wr;
               sda_oe_n <= 1'b0;
               bit_cnt <= '0;
               sub_addr <= sub_addr + `CSR_SUB_STEP;
            end
            csr_st_rd: if (bit_cnt == `CSR_BYTE_BITS) begin
               state <= csr_st_ack_rd;
               sda_oe_n <= 1'b1;
               sub_addr <= sub_addr + `CSR_SUB_STEP;
            end else begin
               sda_oe_n <= shift[6];
               shift <= {shift[6:0], 1'b0};
               bit_cnt <= bit_cnt + `CSR_CNT_ONE;
            end
            csr_st_ack_rd: if (master_nack) begin
               state <= csr_st_idle;
            end else begin
               state <= csr_st_rd;
               shift <= rd_data;
               sda_oe_n <= rd_data[7];
               bit_cnt <= `CSR_CNT_ONE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------
   // Status flags and fault pin
   // ----------------------------------------------------------
   // Set wins over a clear in the same cycle so no event is lost
   always_comb begin
      evt_bits = `CSR_ZERO8;
      evt_bits[`CSR_B_OV] = evt_s.output_overvoltage_flag;
      evt_bits[`CSR_B_TSD] = evt_s.thermal_shutdown_flag;
      evt_bits[`CSR_B_UV] = evt_s.input_undervoltage_flag;
      next_status = status_clr ? `CSR_ZERO8 : status;
      next_status = next_status | evt_bits;
   end

   // Writes never reach the status register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status <= `CSR_STATUS_RST;
      end else begin
         status <= next_status;
      end
   end

   // Pin follows the fault bits only, so a warning never pulls it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_oe_n <= 1'b1;
         fault_out_n <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         fault_oe_n <= ((next_status & `CSR_FAULT_MASK) == `CSR_ZERO8);
         fault_out_n <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------
   // Configuration and nonvolatile control
   // ----------------------------------------------------------
   // Stored values are taken one cycle after reset release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_pending <= 1'b1;
         nv_cfg_out <= '0;
         cfg_unlocked <= 1'b0;
         nonvolatile_program_bit <= 1'b0;
      end else if (load_pending) begin
         load_pending <= 1'b0;
         nv_cfg_out <= nv_cfg_in;
      end else if (wr_now) begin
         if (sub_addr == `CSR_A_UNLOCK) begin
            cfg_unlocked <= shift[`CSR_B_CTRL];
         end
         if (cfg_unlocked && cfg_addr) begin
            unique case (sub_addr)
               `CSR_A_VTERM: nv_cfg_out.vterm <= shift[`CSR_VTERM_MSB:`CSR_VTERM_LSB];
               `CSR_A_ICUR: nv_cfg_out.charge_current_code <= shift[`CSR_ICUR_MSB:`CSR_ICUR_LSB];
               default: nonvolatile_program_bit <= shift[`CSR_B_CTRL];
            endcase
         end
      end
   end

   // One pulse per accepted write of a one; the store copies nv_cfg_out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nv_prog_start <= 1'b0;
      end else begin
         nv_prog_start <= wr_now && cfg_unlocked && !load_pending &&
                          (sub_addr == `CSR_A_NVCTRL) && shift[`CSR_B_CTRL];
      end
   end

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   a_addr_ack: assert property (@(posedge clk) disable iff (rst)
      (scl_fall && !start_det && !stop_det && state == csr_st_addr && bit_cnt == `CSR_BYTE_BITS &&
       shift[7:1] == `CSR_DEV_ADDR) |=> (!sda_oe_n && state == csr_st_ack_addr))
      else $error("address byte not acknowledged");
   a_status_nowrite: assert property (@(posedge clk) disable iff (rst)
      (wr_now && !start_det && !stop_det && sub_addr == `CSR_A_STATUS && !any_evt && !status_clr)
      |=> $stable(status))
      else $error("status register changed by a write");
   a_fault_pulls: assert property (@(posedge clk) disable iff (rst)
      ((status & `CSR_FAULT_MASK) != `CSR_ZERO8) |-> !fault_oe_n)
      else $error("fault bit set but pin released");
   a_warn_only: assert property (@(posedge clk) disable iff (rst)
      (status == `CSR_WARN_ONLY) |-> fault_oe_n)
      else $error("warning pulled the fault pin");
   a_read_clears: assert property (@(posedge clk) disable iff (rst)
      (status_clr && !start_det && !stop_det && !any_evt) |=> (status == `CSR_ZERO8))
      else $error("status not cleared by read");
   a_fault_release: assert property (@(posedge clk) disable iff (rst)
      $rose(fault_oe_n) |-> $past(status_clr))
      else $error("fault pin released without a status read");
   a_cfg_locked: assert property (@(posedge clk) disable iff (rst)
      (wr_now && !cfg_unlocked && !load_pending) |=> ($stable(nv_cfg_out) && $stable(nonvolatile_program_bit)))
      else $error("locked configuration was written");
   a_unlock_bits: assert property (@(posedge clk) disable iff (rst)
      (sub_addr == `CSR_A_UNLOCK) |-> (rd_data[7:1] == 7'h00))
      else $error("unlock register upper bits not zero");
   a_prog_start: assert property (@(posedge clk) disable iff (rst)
      (wr_now && !start_det && !stop_det && cfg_unlocked && !load_pending && sub_addr == `CSR_A_NVCTRL &&
       shift[`CSR_B_CTRL]) |=> (nv_prog_start && nonvolatile_program_bit) ##1 !nv_prog_start)
      else $error("program start pulse wrong");
   a_powerup_load: assert property (@(posedge clk) disable iff (rst)
      $fell(load_pending) |-> (nv_cfg_out == $past(nv_cfg_in)))
      else $error("configuration not loaded at power-up");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
      (sub_addr != `CSR_A_STATUS && sub_addr != `CSR_A_UNLOCK && !cfg_addr) |-> (rd_data == `CSR_ZERO8))
      else $error("unmapped address read nonzero");

endmodule : csr_regs

/* File: verif/csr_host.sv */
`timescale 1ns/100ps
`include "csr_consts.svh"
// ----
// Two-wire bus master model
// ----
// Supply and enable are not modelled; the model never drops them while programming
module csr_host (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_rel
);
   logic [6:0] dev = `CSR_DEV_ADDR;
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // Six clocks per half period: longer than the delay of the three-flop synchroniser chain in the device
   task automatic half();
      repeat (6) @(posedge clk);
      #1;
   endtask : half
   // Start is cond(1,0), stop is cond(0,1); only one line moves at a time
   task automatic cond(input logic a, input logic b);
      scl = 1'b0;
      half();
      sda_rel = a;
      half();
      scl = 1'b1;
      half();
      sda_rel = b;
      half();
   endtask : cond
   // Data moves one clock after the fall, so it never races the clock edge
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      @(posedge clk);
      #1;
      sda_rel = b;
      half();
      scl = 1'b1;
      half();
      r = sda;
   endtask : bit_io
   task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic ackr);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack, ackr);
   endtask : byte_io
   task automatic write_reg(input logic [7:0] sub, input logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2;
      cond(1'b1, 1'b0);
      byte_io({dev, 1'b0}, 1'b1, rx, a0);
      byte_io(sub, 1'b1, rx, a1);
      byte_io(d, 1'b1, rx, a2);
      cond(1'b0, 1'b1);
      ok = !(a0 | a1 | a2);
   endtask : write_reg
   // Last byte is refused with a high ack bit to end the read
   task automatic read_reg(input logic [7:0] sub, output logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, a3;
      cond(1'b1, 1'b0);
      byte_io({dev, 1'b0}, 1'b1, rx, a0);
      byte_io(sub, 1'b1, rx, a1);
      cond(1'b1, 1'b0);
      byte_io({dev, 1'b1}, 1'b1, rx, a2);
      byte_io(8'hFF, 1'b1, d, a3);
      cond(1'b0, 1'b1);
      ok = !(a0 | a1 | a2);
   endtask : read_reg
endmodule : csr_host

/* File: verif/tb.sv */
`timescale 1ns/100ps
`include "csr_consts.svh"
module tb;
   import csr_pkg::*;
   logic clk, rst, scl, sda, host_rel, sda_out, sda_oe_n, fault_out_n, fault_oe_n, prog_bit, prog_start, ok;
   logic [7:0] d, v;
   csr_events_s ev;
   csr_nv_cfg_s nv_in, nv_out;
   logic fault_pin;
   int n_fail = 0, checks = 0, seed = 39828, cycles = 0, n_start = 0;
   csr_regs csr_regs_i (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .fault_out_n(fault_out_n), .fault_oe_n(fault_oe_n), .event_in(ev),
      .nv_cfg_in(nv_in), .nv_cfg_out(nv_out), .nonvolatile_program_bit(prog_bit), .nv_prog_start(prog_start));
   csr_host csr_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_rel(host_rel));
   // Pulled-up data wire: low when either side pulls
   assign sda = host_rel & (sda_oe_n | sda_out);
   // Pulled-up fault wire: low only while the device drives its output value
   assign fault_pin = fault_oe_n | fault_out_n;
   // ----
   // Clock, cycle ceiling and start-pulse count
   // ----
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (prog_start === 1'b1)
         n_start++;
      if (cycles == 80000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      csr_host_i.write_reg(a, x, ok);
      chk({7'h00, ok}, 8'h01);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      csr_host_i.read_reg(a, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, e);
   endtask : rd_chk
   task automatic settle();
      repeat (10) @(posedge clk);
      #1;
   endtask : settle
   function automatic logic [7:0] stat_of(input logic [2:0] e);
      return {e[2], 3'h0, e[1], 1'b0, e[0], 1'b0};
   endfunction : stat_of
   task automatic print_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : print_verdict
   // ----
   // Main sequence
   // ----
   initial begin
      rst = 1'b1;
      ev = '0;
      nv_in = 7'($random(seed));
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk({1'b0, nv_out}, {1'b0, nv_in});
      chk({7'h00, fault_pin}, 8'h01);
      rd_chk(`CSR_A_UNLOCK, 8'h00);
      rd_chk(`CSR_A_NVCTRL, 8'h00);
      wr(`CSR_A_STATUS, 8'hFF);
      rd_chk(`CSR_A_STATUS, 8'h00);
      // Locked writes must not land, though they are still acknowledged
      wr(`CSR_A_VTERM, 8'hFF);
      wr(`CSR_A_NVCTRL, 8'h01);
      chk({1'b0, nv_out}, {1'b0, nv_in});
      chk({7'h00, prog_bit}, 8'h00);
      rd_chk(`CSR_A_ICUR, 8'h00);
      $display("test reset and lock done");
      wr(`CSR_A_UNLOCK, 8'hFF);
      rd_chk(`CSR_A_UNLOCK, 8'h01);
      rd_chk(`CSR_A_VTERM, {2'h0, nv_in.vterm, 3'h0});
      // Every current code and termination codes 0 to 6, with random noise in the unused bits
      for (int i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         v[5:3] = 3'(i % 7);
         wr(`CSR_A_VTERM, v);
         wr(`CSR_A_ICUR, {4'(i), v[3:0]});
         rd_chk(`CSR_A_VTERM, v & 8'h38);
         rd_chk(`CSR_A_ICUR, {4'(i), 4'h0});
         chk({1'b0, nv_out}, {1'b0, 3'(i % 7), 4'(i)});
      end
      $display("test configuration done");
      // Mid-run reset: lock drops, the store is reloaded, then access is reopened
      nv_in = 7'($random(seed));
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      @(posedge clk);
      #1;
      chk({1'b0, nv_out}, {1'b0, nv_in});
      rd_chk(`CSR_A_UNLOCK, 8'h00);
      rd_chk(`CSR_A_VTERM, 8'h00);
      wr(`CSR_A_UNLOCK, 8'h01);
      $display("test mid-run reset done");
      wr(`CSR_A_NVCTRL, 8'hFF);
      chk({7'h00, prog_bit}, 8'h01);
      chk(8'(n_start), 8'h01);
      rd_chk(`CSR_A_NVCTRL, 8'h01);
      wr(`CSR_A_NVCTRL, 8'h00);
      chk({7'h00, prog_bit}, 8'h00);
      chk(8'(n_start), 8'h01);
      $display("test program done");
      for (int a = 1; a < 17; a++) begin
         if (a == 2 || a == 4)
            continue;
         wr(8'(a), 8'($random(seed)));
         rd_chk(8'(a), 8'h00);
      end
      $display("test unmapped done");
      // Each event mix: pulse, then read-clear releases the pin
      for (int e = 0; e < 8; e++) begin
         ev = 3'(e);
         settle();
         ev = '0;
         chk({7'h00, fault_pin}, {7'h00, !(e[2] | e[1])});
         rd_chk(`CSR_A_STATUS, stat_of(3'(e)));
         chk({7'h00, fault_pin}, 8'h01);
         rd_chk(`CSR_A_STATUS, 8'h00);
      end
      // A fault still present at the read keeps the pin low
      ev = 3'h2;
      settle();
      rd_chk(`CSR_A_STATUS, 8'h08);
      chk({7'h00, fault_pin}, 8'h00);
      ev = '0;
      rd_chk(`CSR_A_STATUS, 8'h08);
      chk({7'h00, fault_pin}, 8'h01);
      $display("test status done");
      csr_host_i.dev = 7'h49;
      csr_host_i.write_reg(`CSR_A_UNLOCK, 8'h00, ok);
      chk({7'h00, ok}, 8'h00);
      csr_host_i.dev = `CSR_DEV_ADDR;
      rd_chk(`CSR_A_UNLOCK, 8'h01);
      wr(`CSR_A_UNLOCK, 8'h00);
      rd_chk(`CSR_A_VTERM, 8'h00);
      $display("test address and relock done");
      print_verdict();
   end
endmodule : tb
